// ===== rtl/smb_pkg.sv
// shared constants, carriers and address decoding for the two-wire slave
// assumes a 250 MHz system clock and a serial clock from the bus master
package smb_pkg;

  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned TO_W = 23;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] ADDR_ARA = 7'h0C;
  localparam logic [6:0] ADDR_MASS = 7'h63;
  localparam logic [7:0] CMD_FIRST = 8'hD0;
  localparam logic [7:0] CMD_LAST = 8'hE4;
  localparam logic [7:0] ADDR_FALLBACK = 8'h98;
  localparam logic [15:0] ACKED_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // three-state strap levels
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_HIGH = 2'h1;
  localparam logic [1:0] PIN_OPEN = 2'h2;

  typedef struct packed {
    logic [1:0] pin_c;
    logic [1:0] pin_b;
    logic [1:0] pin_a;
  } smb_addr_pins_t;

  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
    logic [7:0] data;
  } smb_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_TX, ST_MACK, ST_WAIT
  } smb_state_t;

  // strap levels (c,b,a) to the 7-bit slave address
  function automatic logic [6:0] smb_addr_decode(input smb_addr_pins_t p);
    logic [7:0] a8;
    a8 = ADDR_FALLBACK;
    case ({p.pin_c, p.pin_b, p.pin_a})
      6'h08: a8 = 8'h88;
      6'h06: a8 = 8'h8A;
      6'h0A: a8 = 8'h8C;
      6'h09: a8 = 8'h8E;
      6'h00: a8 = 8'h98;
      6'h05: a8 = 8'h9A;
      6'h02: a8 = 8'h9C;
      6'h01: a8 = 8'h9E;
      6'h28: a8 = 8'hA8;
      6'h26: a8 = 8'hAA;
      6'h2A: a8 = 8'hAC;
      6'h29: a8 = 8'hAE;
      6'h20: a8 = 8'hB8;
      6'h25: a8 = 8'hBA;
      6'h22: a8 = 8'hBC;
      6'h21: a8 = 8'hBE;
      6'h18: a8 = 8'hC8;
      6'h16: a8 = 8'hCA;
      6'h1A: a8 = 8'hCC;
      6'h19: a8 = 8'hCE;
      6'h10: a8 = 8'hD8;
      6'h15: a8 = 8'hDA;
      6'h12: a8 = 8'hDC;
      6'h11: a8 = 8'hDE;
      6'h04: a8 = 8'hE8;
      6'h24: a8 = 8'hEA;
      6'h14: a8 = 8'hEC;
      default: a8 = ADDR_FALLBACK;
    endcase
    return a8[7:1];
  endfunction

endpackage

// ===== rtl/smb_slave.sv
// two-wire slave with alert handling and bus timeout
// assumes register storage, fault logs and alert enables live outside on clk_i
//
// Operation
// - on acking a read's command byte, latch the whole byte as pointer.
// - read uses repeated START and read bit; slave acks then sends register.
// - master ack after a data byte makes the slave resend the same register.
// - alert pulled low while any enabled fault log bit not yet acknowledged is set.
// - on alert response address, send own address then release alert.
// - alert also released when addressed at own slave address.
// - no new alert until a different fault, or the old one clears and recurs.
// - own address from three three-state straps; mass-write address also accepted.
// - mass-write address ignored when the mass-write enable is zero.
// - either line low beyond 25 ms resets the interface and frees data.
// - unsupported command bytes are not acknowledged.
`timescale 1ns/1ps

module smb_slave #(
  parameter int unsigned TIMEOUT_LIMIT = smb_pkg::TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic alert_n_o,
  input wire smb_pkg::smb_addr_pins_t addr_pins_i,
  input wire logic mass_wr_en_i,
  input wire logic [15:0] fault_log_i,
  input wire logic [15:0] alert_en_i,
  input wire logic [7:0] rd_data_i,
  output logic [7:0] cmd_o,
  output smb_pkg::smb_wr_t wr_o
);
  import smb_pkg::*;

  // ************************************************************
  // link domain: sample data on each serial clock rise
  // ************************************************************
  logic lk_bit_r = 1'b1;
  logic lk_tog_r = 1'b0;

  always_ff @(posedge scl_i) begin
    lk_bit_r <= sda_i;
    lk_tog_r <= ~lk_tog_r;
  end

  // ************************************************************
  // pin and toggle synchronisers, three stages each
  // ************************************************************
  logic [2:0] scl_s_r, sda_s_r, tog_s_r;
  logic scl_f_r, sda_f_r, tog_seen_r;
  logic scl_f_nxt, sda_f_nxt;
  logic scl_fall, bus_start, bus_stop, bit_ev;
  smb_addr_pins_t strap_s0_r, strap_s1_r, strap_s2_r;

  always_ff @(posedge clk_i) begin
    scl_s_r <= {scl_s_r[1:0], scl_i};
    sda_s_r <= {sda_s_r[1:0], sda_i};
    tog_s_r <= {tog_s_r[1:0], lk_tog_r};
    strap_s0_r <= addr_pins_i;
    strap_s1_r <= strap_s0_r;
    strap_s2_r <= strap_s1_r;
  end

  assign scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
  assign sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
  assign scl_fall = scl_f_r & ~scl_f_nxt;
  assign bus_start = scl_f_r & scl_f_nxt & sda_f_r & ~sda_f_nxt;
  assign bus_stop = scl_f_r & scl_f_nxt & ~sda_f_r & sda_f_nxt;
  assign bit_ev = (tog_s_r[1] == tog_s_r[2]) && (tog_s_r[2] != tog_seen_r);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      tog_seen_r <= tog_s_r[2];
    end else begin
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
      if (bit_ev) begin
        tog_seen_r <= tog_s_r[2];
      end
    end
  end

  // ************************************************************
  // stuck bus timeout, one low-time counter per line
  // ************************************************************
  logic [TO_W-1:0] scl_lo_r, sda_lo_r;
  logic timeout;

  // clears while the line is high, stops at the limit
  function automatic logic [TO_W-1:0] lo_step(input logic line_hi, input logic [TO_W-1:0] n);
    logic [TO_W-1:0] r;
    r = n;
    if (line_hi) begin
      r = '0;
    end else if (n != TO_W'(TIMEOUT_LIMIT)) begin
      r = n + TO_W'(1);
    end
    return r;
  endfunction

  assign timeout = (scl_lo_r == TO_W'(TIMEOUT_LIMIT)) ||
    (sda_lo_r == TO_W'(TIMEOUT_LIMIT));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_lo_r <= '0;
      sda_lo_r <= '0;
    end else begin
      scl_lo_r <= lo_step(scl_f_r, scl_lo_r);
      sda_lo_r <= lo_step(sda_f_r, sda_lo_r);
    end
  end

  // ************************************************************
  // byte engine decode
  // ************************************************************
  smb_state_t state_r, state_nxt, after_r, after_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, cmd_r, cmd_nxt;
  logic [6:0] own_addr_r;
  logic ara_r, ara_nxt, first_r, first_nxt, oe_n_r, oe_n_nxt;
  smb_wr_t wr_r, wr_nxt;
  logic release_alert;
  logic [15:0] acked_r, acked_nxt, fault_live;
  logic alert_n_r;

  wire byte_done = (cnt_r == BYTE_BITS) && scl_fall;
  wire [6:0] rx_addr = sh_r[7:1];
  wire rx_read = sh_r[0];
  wire hit_own = (rx_addr == own_addr_r);
  wire hit_mass = (rx_addr == ADDR_MASS) && !rx_read && mass_wr_en_i;
  wire hit_ara = (rx_addr == ADDR_ARA) && rx_read && !alert_n_r;
  wire cmd_ok = (sh_r >= CMD_FIRST) && (sh_r <= CMD_LAST);
  wire [7:0] tx_src = ara_r ? {own_addr_r, 1'b0} : rd_data_i;

  always_comb begin
    state_nxt = state_r;
    after_nxt = after_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    cmd_nxt = cmd_r;
    ara_nxt = ara_r;
    first_nxt = first_r;
    oe_n_nxt = oe_n_r;
    wr_nxt = '{valid: 1'b0, cmd: cmd_r, data: sh_r};
    release_alert = 1'b0;
    if (timeout || bus_stop) begin
      state_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
    end else if (bus_start) begin
      state_nxt = ST_ADDR;
      cnt_nxt = '0;
      ara_nxt = 1'b0;
      oe_n_nxt = 1'b1;
    end else begin
      case (state_r)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (bit_ev) begin
            sh_nxt = {sh_r[6:0], lk_bit_r};
            cnt_nxt = cnt_r + 4'h1;
          end
          if (byte_done) begin
            state_nxt = ST_WAIT;
            if (state_r == ST_ADDR && (hit_own || hit_mass || hit_ara)) begin
              oe_n_nxt = 1'b0;
              state_nxt = ST_ACK;
              after_nxt = rx_read ? ST_TX : ST_CMD;
              ara_nxt = hit_ara;
              first_nxt = 1'b1;
              release_alert = hit_own;
            end else if (state_r == ST_CMD && cmd_ok) begin
              oe_n_nxt = 1'b0;
              state_nxt = ST_ACK;
              after_nxt = ST_WDATA;
              cmd_nxt = sh_r;
            end else if (state_r == ST_WDATA) begin
              oe_n_nxt = 1'b0;
              state_nxt = ST_ACK;
              first_nxt = 1'b0;
              wr_nxt.valid = first_r;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_nxt = '0;
            state_nxt = after_r;
            oe_n_nxt = 1'b1;
            if (after_r == ST_TX) begin
              oe_n_nxt = tx_src[7];
              tx_nxt = {tx_src[6:0], 1'b0};
              cnt_nxt = 4'h1;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin
              oe_n_nxt = 1'b1;
              state_nxt = ST_MACK;
              release_alert = ara_r;
            end else begin
              oe_n_nxt = tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (bit_ev) begin
            state_nxt = lk_bit_r ? ST_WAIT : ST_ACK;
            after_nxt = ST_TX;
          end
        end
        ST_IDLE, ST_WAIT: begin
          state_nxt = state_r;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // alert tracking
  // ************************************************************
  assign fault_live = fault_log_i & alert_en_i;
  assign acked_nxt = (acked_r & fault_log_i) | (release_alert ? fault_live : ACKED_RST);

  // ************************************************************
  // state registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      after_r <= ST_IDLE;
      cnt_r <= '0;
      sh_r <= BYTE_RST;
      tx_r <= BYTE_RST;
      cmd_r <= BYTE_RST;
      ara_r <= 1'b0;
      first_r <= 1'b0;
      oe_n_r <= 1'b1;
      wr_r <= '0;
      acked_r <= ACKED_RST;
      alert_n_r <= 1'b1;
      if (strap_s1_r == strap_s2_r) begin
        own_addr_r <= smb_addr_decode(strap_s2_r);
      end
    end else begin
      state_r <= state_nxt;
      after_r <= after_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      cmd_r <= cmd_nxt;
      ara_r <= ara_nxt;
      first_r <= first_nxt;
      oe_n_r <= oe_n_nxt;
      wr_r <= wr_nxt;
      acked_r <= acked_nxt;
      alert_n_r <= ~(|(fault_live & ~acked_nxt));
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = oe_n_r;
  assign alert_n_o = alert_n_r;
  assign cmd_o = cmd_r;
  assign wr_o = wr_r;

endmodule

// ===== tb/smb_master.sv
// bus master model: open-drain data, serial clock idle high between frames
// assumes a pull-up on the data wire
`timescale 1ns/1ps
// ********
// master
// ********
module smb_master (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // edges on the 22.5 ns grid of the 67.5 ns link clock
  localparam realtime T = 22.5;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic bstart();
    #T sda_o = 1'b1;
    #T scl_o = 1'b1;
    #T sda_o = 1'b0;
    #T scl_o = 1'b0;
  endtask
  task automatic bstop();
    #T sda_o = 1'b0;
    #T scl_o = 1'b1;
    #T sda_o = 1'b1;
  endtask
  task automatic sbit(input logic d, output logic q);
    #T sda_o = d;
    #T scl_o = 1'b1;
    #T q = sda_i;
    scl_o = 1'b0;
  endtask
  // byte msb first, then acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      sbit(d[i], q[i]);
    end
    sbit(a, k);
  endtask
endmodule

// ===== tb/smb_monitor.sv
// port checker for the two-wire slave, bound into the design
// assumes every checked signal lives in the clk_i domain
`timescale 1ns/1ps
// ********
// checker
// ********
module smb_monitor #(
  parameter int unsigned TIMEOUT_LIMIT = 200
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_oe_n_o,
  input wire logic alert_n_o,
  input wire logic [15:0] fault_log_i,
  input wire logic [15:0] alert_en_i,
  input wire logic [7:0] cmd_o,
  input wire smb_pkg::smb_wr_t wr_o
);
  import smb_pkg::*;
  logic [15:0] act_r;
  int unsigned lo_r;
  // enabled faults one cycle back, and serial clock low time
  always_ff @(posedge clk_i) begin
    act_r <= fault_log_i & alert_en_i;
    lo_r <= scl_i ? 0 : lo_r + 1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  rst_idle_a: assert property ($fell(reset_i) |-> sda_oe_n_o && alert_n_o && cmd_o == 8'h00)
    else $error("outputs not idle after reset");
  wr_pulse_a: assert property (wr_o.valid |=> !wr_o.valid)
    else $error("write pulse too long");
  wr_ack_a: assert property (wr_o.valid |-> ##[0:6] !sda_oe_n_o)
    else $error("stored byte not acked");
  cmd_range_a: assert property ($changed(cmd_o) |-> cmd_o >= 8'hD0 && cmd_o <= 8'hE4)
    else $error("unsupported command latched");
  alert_cause_a: assert property (!alert_n_o |-> act_r != 16'h0000)
    else $error("alert without enabled fault");
  alert_new_a: assert property (act_r != 16'h0000 && $past(act_r) == 16'h0000 |-> !alert_n_o)
    else $error("new fault gave no alert");
  alert_hold_a: assert property (
    $past(alert_n_o) && act_r == $past(act_r) && !$past(reset_i) && !$past(reset_i, 2)
    |-> alert_n_o)
    else $error("alert raised without new fault");
  bus_free_a: assert property (lo_r > TIMEOUT_LIMIT + 8 |-> sda_oe_n_o)
    else $error("data held after timeout");
endmodule
bind smb_slave smb_monitor #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) u_mon (.clk_i, .reset_i, .scl_i,
  .sda_oe_n_o, .alert_n_o, .fault_log_i, .alert_en_i, .cmd_o, .wr_o);

// ===== tb/tb_smbus_slave_alert_interface.sv
// self-checking bench: master model on the bus, register side modelled here
// assumes the monitor is bound by its own file
`timescale 1ns/1ps
// ********
// bench
// ********
module tb_smbus_slave_alert_interface;
  import smb_pkg::*;
  localparam int unsigned LIM = 600;
  localparam logic [5:0] PINS [3] = '{6'h14, 6'h2A, 6'h06};
  localparam logic [7:0] ADRS [3] = '{8'hEC, 8'hAC, 8'h8A};
  logic clk_i, scl_i, m_sda, sda_o, sda_oe_n_o, alert_n_o, k1;
  logic reset_i = 1'b1;
  logic mass_wr_en_i = 1'b1;
  logic [15:0] fault_log_i = '0;
  logic [15:0] alert_en_i = '0;
  logic [7:0] rd_data_i = '0;
  logic [7:0] cmd_o, c, d, q, q2;
  logic [2:0] k;
  smb_addr_pins_t addr_pins_i = '0;
  smb_wr_t wr_o, wr_seen;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_wr = 0;
  int n0;
  int seed = 32'h270C;
  wire sda_i = m_sda & (sda_oe_n_o | sda_o);
  smb_slave #(.TIMEOUT_LIMIT(LIM)) dut (.clk_i, .reset_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o,
    .alert_n_o, .addr_pins_i, .mass_wr_en_i, .fault_log_i, .alert_en_i, .rd_data_i, .cmd_o,
    .wr_o);
  smb_master u_m (.scl_o(scl_i), .sda_o(m_sda), .sda_i);
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // register side: reads return the inverted pointer, writes captured
  always @(posedge clk_i) begin
    rd_data_i <= ~cmd_o;
    cyc <= cyc + 1;
    if (wr_o.valid) begin
      wr_seen <= wr_o;
      n_wr <= n_wr + 1;
    end
    if (cyc == 40000) begin
      n_fail++;
      end_of_test();
    end
  end
  function automatic logic [7:0] rnd_cmd();
    return 8'hD0 + 8'($unsigned($random(seed)) % 21);
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] cm);
    return ~cm;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input smb_addr_pins_t p);
    @(posedge clk_i);
    addr_pins_i <= p;
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic flt(input logic [15:0] en, input logic [15:0] v);
    @(posedge clk_i);
    alert_en_i <= en;
    fault_log_i <= v;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic wr3(input logic [7:0] a, input logic [7:0] cm, input logic [7:0] dt);
    u_m.bstart();
    u_m.xfer(a, 1'b1, q, k[2]);
    u_m.xfer(cm, 1'b1, q, k[1]);
    u_m.xfer(dt, 1'b1, q, k[0]);
    u_m.bstop();
  endtask
  task automatic ara();
    u_m.bstart();
    u_m.xfer(8'h19, 1'b1, q, k[0]);
    u_m.xfer(8'hFF, 1'b1, q, k1);
    u_m.bstop();
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    do_reset(6'h00);
    for (int i = 0; i < 6; i++) begin
      c = (i == 0) ? 8'hD0 : (i == 1) ? 8'hE4 : rnd_cmd();
      d = 8'($random(seed));
      wr3(8'h98, c, d);
      chk(k, 8'h00);
      chk(wr_seen.cmd, c);
      chk(wr_seen.data, d);
    end
    n0 = n_wr;
    wr3(8'h98, 8'hE5, 8'h11);
    chk(k, 8'h03);
    wr3(8'h98, 8'hCF, 8'h22);
    chk(k, 8'h03);
    chk(8'(n_wr - n0), 8'h00);
    wr3(8'hC6, 8'hD4, 8'h10);
    chk(k, 8'h00);
    @(posedge clk_i) mass_wr_en_i <= 1'b0;
    wr3(8'hC6, 8'hD4, 8'h10);
    chk(k, 8'h07);
    @(posedge clk_i) mass_wr_en_i <= 1'b1;
    $display("write tests done");
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 8'hE4 : rnd_cmd();
      u_m.bstart();
      u_m.xfer(8'h98, 1'b1, q, k[2]);
      u_m.xfer(c, 1'b1, q, k[1]);
      u_m.bstart();
      u_m.xfer(8'h99, 1'b1, q, k[0]);
      u_m.xfer(8'hFF, 1'b0, q, k1);
      u_m.xfer(8'hFF, 1'b1, q2, k1);
      u_m.bstop();
      chk(k, 8'h00);
      chk(cmd_o[2:0], c[2:0]);
      chk(q, exp_rd(c));
      chk(q2, exp_rd(c));
    end
    $display("read test done");
    flt(16'h0002, 16'h0001);
    chk(alert_n_o, 8'h01);
    flt(16'h0003, 16'h0001);
    chk(alert_n_o, 8'h00);
    ara();
    chk(k[0], 8'h00);
    chk(q, 8'h98);
    chk(alert_n_o, 8'h01);
    ara();
    chk(k[0], 8'h01);
    chk(alert_n_o, 8'h01);
    flt(16'h0003, 16'h0003);
    chk(alert_n_o, 8'h00);
    wr3(8'h98, 8'hD1, 8'h03);
    chk(alert_n_o, 8'h01);
    flt(16'h0003, 16'h0000);
    flt(16'h0003, 16'h0002);
    chk(alert_n_o, 8'h00);
    wr3(8'h98, 8'hD1, 8'h03);
    flt(16'h0000, 16'h0000);
    $display("alert test done");
    for (int i = 0; i < 3; i++) begin
      do_reset(PINS[i]);
      wr3(ADRS[i], 8'hD0, 8'h5A);
      chk(k, 8'h00);
      wr3(8'h98, 8'hD0, 8'h5A);
      chk(k, 8'h07);
    end
    $display("address test done");
    u_m.bstart();
    for (int i = 7; i >= 0; i--) begin
      u_m.sbit(ADRS[2][i], k1);
    end
    #30;
    chk(sda_oe_n_o, 8'h00);
    #2600;
    chk(sda_oe_n_o, 8'h01);
    u_m.bstop();
    wr3(8'h8A, 8'hD2, 8'h33);
    chk(k, 8'h00);
    $display("timeout test done");
    end_of_test();
  end
endmodule
